// ### verilog/iocm_pkg.sv
`default_nettype none
package iocm_pkg;
  localparam int unsigned NUM_GEN  = 8;
  localparam int unsigned NUM_CH   = 16;
  localparam int unsigned OFS_W    = 9;
  localparam int unsigned FIFO_DEP = 16;
  localparam int unsigned CFG_W    = OFS_W + 8 + 1;

  // byte offsets in the configuration assembly
  localparam logic [8:0] OFS_FORCE_LOCK = 9'h001;
  localparam logic [8:0] OFS_WEB_LOCK   = 9'h002;
  localparam logic [8:0] OFS_OUT_SRC    = 9'h003;
  localparam logic [8:0] OFS_SUPPLY_REP = 9'h004;
  localparam logic [8:0] OFS_DO_REP     = 9'h005;
  localparam logic [8:0] OFS_OBJ_LOCK   = 9'h018;
  localparam logic [8:0] OFS_ALT_LOCK   = 9'h019;
  localparam logic [8:0] OFS_MAP_MODE   = 9'h01F;
  localparam logic [8:0] OFS_MAP_BASE   = 9'h020;

  // slots of the general settings array
  localparam logic [2:0] IDX_FORCE_LOCK = 3'h0;
  localparam logic [2:0] IDX_WEB_LOCK   = 3'h1;
  localparam logic [2:0] IDX_OUT_SRC    = 3'h2;
  localparam logic [2:0] IDX_SUPPLY_REP = 3'h3;
  localparam logic [2:0] IDX_DO_REP     = 3'h4;
  localparam logic [2:0] IDX_OBJ_LOCK   = 3'h5;
  localparam logic [2:0] IDX_ALT_LOCK   = 3'h6;
  localparam logic [2:0] IDX_MAP_MODE   = 3'h7;

  localparam logic [7:0] GEN_RST [NUM_GEN] = '{8'h00, 8'h00, 8'h00, 8'h01,
                                               8'h01, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] VAL_ENABLE    = 8'h01;
  localparam logic [7:0] MODE_DEFAULT  = 8'h00;
  localparam logic [7:0] MODE_SWAP     = 8'h01;
  localparam logic [7:0] MODE_A_LOW    = 8'h02;
  localparam logic [7:0] MODE_B_LOW    = 8'h03;
  localparam logic [7:0] MODE_FREE     = 8'h04;
  localparam logic [7:0] MAP_INACTIVE  = 8'h10;

  localparam logic [3:0] ERR_NONE      = 4'h0;
  localparam logic [3:0] ERR_MODE      = 4'h1;
  localparam logic [3:0] ERR_MAP_RANGE = 4'h2;
  localparam logic [3:0] ERR_MAP_DUP   = 4'h3;

  typedef enum logic [1:0] {
    ST_LOAD  = 2'b01,
    ST_CHECK = 2'b10
  } iocm_state_e;
endpackage
`default_nettype wire

// ### verilog/iocm_top.sv
// What this block does
// - owner sends run/idle framed output data; outputs follow it only while running.
// - input status word is produced for owning and listen-only connections alike.
// - accepted configuration assembly replaces every parameter and beats other sources.
// - force lock enabled blocks all forcing through alternative interfaces.
// - web lock set to one makes the web pages unreachable.
// - output source byte picks channel control word or attached-device output byte.
// - byte four enables or suppresses the missing supply diagnosis.
// - byte five enables or suppresses output-without-supply actuator diagnosis.
// - object writes accepted without owner, refused when object lock is set.
// - object lock is cleared only by a configuration assembly at owner setup.
// - alternative writes only without cyclic connection, gated by external lock.
// - each new controller configuration overwrites alternative interface settings.
// - mapping mode selects one of five mappings, same for output and input.
// - mode zero orders ports one to eight; mode one swaps the bytes.
// - mode two: low byte carries first channels, high byte second channels.
// - mode three: low byte carries second channels, high byte first channels.
// - mode four takes each channel's bit position from the user table.
// - table entry is 0..15 or 16 inactive; duplicates reject the configuration.
`timescale 1ns/1ps
`default_nettype none

module iocm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // fill side
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("iocm_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;

  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign o_in_ready  = !full;
  assign o_out_valid = !empty;
  assign o_out_data  = mem[rd_q[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (i_in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (i_out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

module iocm_top import iocm_pkg::*; #(
  parameter int unsigned FIFO_DEPTH = FIFO_DEP
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // connection state from the protocol stack
  input  wire logic             i_owner_active,
  input  wire logic             i_owner_setup,
  input  wire logic             i_listen_active,
  input  wire logic             i_run,
  // configuration assembly byte stream
  input  wire logic             i_cfg_valid,
  output logic                  o_cfg_ready,
  input  wire logic [OFS_W-1:0] i_cfg_ofs,
  input  wire logic [7:0]       i_cfg_data,
  input  wire logic             i_cfg_last,
  output logic                  o_cfg_done,
  output logic [3:0]            o_cfg_err,
  // vendor object service writes
  input  wire logic             i_obj_wr,
  input  wire logic [OFS_W-1:0] i_obj_ofs,
  input  wire logic [7:0]       i_obj_data,
  output logic                  o_obj_ack,
  output logic                  o_obj_refused,
  // alternative interface writes
  input  wire logic             i_alt_wr,
  input  wire logic [OFS_W-1:0] i_alt_ofs,
  input  wire logic [7:0]       i_alt_data,
  output logic                  o_alt_ack,
  output logic                  o_alt_refused,
  // parameter readback
  input  wire logic [OFS_W-1:0] i_rd_ofs,
  output logic [7:0]            o_rd_data,
  // controls for the rest of the device
  input  wire logic             i_force_req,
  output logic                  o_force_grant,
  output logic                  o_web_enable,
  output logic                  o_out_src_device,
  output logic                  o_supply_diag_en,
  output logic                  o_do_fault_diag_en,
  // process data
  input  wire logic [15:0]      i_out_word,
  output logic [15:0]           o_chan_out,
  input  wire logic [15:0]      i_chan_in,
  output logic [15:0]           o_status_word
);
  // general offset decode: {hit, slot}
  function automatic logic [3:0] gen_dec(input logic [OFS_W-1:0] ofs);
    unique case (ofs)
      OFS_FORCE_LOCK: gen_dec = {1'b1, IDX_FORCE_LOCK};
      OFS_WEB_LOCK:   gen_dec = {1'b1, IDX_WEB_LOCK};
      OFS_OUT_SRC:    gen_dec = {1'b1, IDX_OUT_SRC};
      OFS_SUPPLY_REP: gen_dec = {1'b1, IDX_SUPPLY_REP};
      OFS_DO_REP:     gen_dec = {1'b1, IDX_DO_REP};
      OFS_OBJ_LOCK:   gen_dec = {1'b1, IDX_OBJ_LOCK};
      OFS_ALT_LOCK:   gen_dec = {1'b1, IDX_ALT_LOCK};
      OFS_MAP_MODE:   gen_dec = {1'b1, IDX_MAP_MODE};
      default:        gen_dec = 4'h0;
    endcase
  endfunction

  function automatic logic map_hit(input logic [OFS_W-1:0] ofs);
    map_hit = (ofs >= OFS_MAP_BASE) && (ofs < OFS_MAP_BASE + OFS_W'(NUM_CH));
  endfunction

  // word bit position of channel ch (ch = 2*(port-1) + second channel)
  function automatic logic [4:0] word_pos(input logic [7:0] mode, input logic [3:0] ch,
                                          input logic [7:0] user);
    unique case (mode)
      MODE_DEFAULT: word_pos = {1'b0, ch};
      MODE_SWAP:    word_pos = {1'b0, ~ch[3], ch[2:0]};
      MODE_A_LOW:   word_pos = {1'b0, ch[0], ch[3:1]};
      MODE_B_LOW:   word_pos = {1'b0, ~ch[0], ch[3:1]};
      default:      word_pos = user[4:0];
    endcase
  endfunction

  logic [7:0]  gen_q    [NUM_GEN];
  logic [7:0]  sh_q     [NUM_GEN];
  logic [7:0]  map_q    [NUM_CH];
  logic [7:0]  sh_map_q [NUM_CH];
  logic        first_q;
  iocm_state_e st_q;
  logic [3:0]  chk_err;
  logic        commit;
  logic        f_valid;
  logic        f_ready;
  logic [CFG_W-1:0] f_data;
  logic [OFS_W-1:0] f_ofs;
  logic [7:0]  f_byte;
  logic        f_last;
  logic        pop;
  logic [3:0]  pop_dec;
  logic [3:0]  obj_dec;
  logic [3:0]  alt_dec;
  logic [3:0]  rd_dec;
  logic        obj_ok;
  logic        alt_ok;
  logic        run_ok;
  logic [4:0]  pos [NUM_CH];

  // bytes seen outside owner setup are taken and dropped
  iocm_fifo #(.WIDTH(CFG_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_in_valid  (i_cfg_valid && i_owner_setup),
    .o_in_ready  (f_ready),
    .i_in_data   ({i_cfg_ofs, i_cfg_data, i_cfg_last}),
    .o_out_valid (f_valid),
    .i_out_ready (st_q == ST_LOAD),
    .o_out_data  (f_data)
  );
  assign o_cfg_ready = f_ready || !i_owner_setup;
  assign {f_ofs, f_byte, f_last} = f_data;
  assign pop     = f_valid && (st_q == ST_LOAD);
  assign pop_dec = gen_dec(f_ofs);

  // whole-image check before anything is applied
  always_comb begin
    chk_err = ERR_NONE;
    for (int i = 0; i < NUM_CH; i++) begin
      if (sh_map_q[i] > MAP_INACTIVE) begin
        chk_err = ERR_MAP_RANGE;
      end
      for (int j = i + 1; j < NUM_CH; j++) begin
        if (sh_map_q[i] != MAP_INACTIVE && sh_map_q[i] == sh_map_q[j]) begin
          chk_err = ERR_MAP_DUP;
        end
      end
    end
    if (sh_q[IDX_MAP_MODE] > MODE_FREE) begin
      chk_err = ERR_MODE;
    end
  end
  assign commit = (st_q == ST_CHECK) && (chk_err == ERR_NONE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_LOAD;
    end else begin
      unique case (st_q)
        ST_LOAD:  if (pop && f_last) st_q <= ST_CHECK;
        ST_CHECK: st_q <= ST_LOAD;
      endcase
    end
  end

  // each assembly starts from defaults so that it replaces everything
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      first_q <= 1'b1;
      for (int i = 0; i < NUM_GEN; i++) sh_q[i] <= GEN_RST[i];
      for (int i = 0; i < NUM_CH; i++) sh_map_q[i] <= 8'(i);
    end else if (pop) begin
      first_q <= f_last;
      if (first_q) begin
        for (int i = 0; i < NUM_GEN; i++) sh_q[i] <= GEN_RST[i];
        for (int i = 0; i < NUM_CH; i++) sh_map_q[i] <= 8'(i);
      end
      if (pop_dec[3]) begin
        sh_q[pop_dec[2:0]] <= f_byte;
      end
      if (map_hit(f_ofs)) begin
        sh_map_q[4'(f_ofs - OFS_MAP_BASE)] <= f_byte;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_done <= 1'b0;
      o_cfg_err  <= ERR_NONE;
    end else begin
      o_cfg_done <= (st_q == ST_CHECK);
      if (st_q == ST_CHECK) begin
        o_cfg_err <= chk_err;
      end
    end
  end

  // writes from the other sources; an assembly commit wins the cycle
  assign obj_dec = gen_dec(i_obj_ofs);
  assign alt_dec = gen_dec(i_alt_ofs);
  assign rd_dec  = gen_dec(i_rd_ofs);
  assign obj_ok  = i_obj_wr && !commit && obj_dec[3] && !i_owner_active
                   && (gen_q[IDX_OBJ_LOCK] != VAL_ENABLE)
                   && !(obj_dec[2:0] == IDX_MAP_MODE && i_obj_data > MODE_FREE);
  assign alt_ok  = i_alt_wr && !commit && !obj_ok && alt_dec[3]
                   && !i_owner_active && !i_listen_active
                   && (gen_q[IDX_ALT_LOCK] != VAL_ENABLE)
                   && (alt_dec[2:0] != IDX_OBJ_LOCK)
                   && !(alt_dec[2:0] == IDX_MAP_MODE && i_alt_data > MODE_FREE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_GEN; i++) gen_q[i] <= GEN_RST[i];
      for (int i = 0; i < NUM_CH; i++) map_q[i] <= 8'(i);
    end else if (commit) begin
      for (int i = 0; i < NUM_GEN; i++) gen_q[i] <= sh_q[i];
      for (int i = 0; i < NUM_CH; i++) map_q[i] <= sh_map_q[i];
    end else if (obj_ok) begin
      gen_q[obj_dec[2:0]] <= i_obj_data;
    end else if (alt_ok) begin
      gen_q[alt_dec[2:0]] <= i_alt_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_obj_ack     <= 1'b0;
      o_obj_refused <= 1'b0;
      o_alt_ack     <= 1'b0;
      o_alt_refused <= 1'b0;
      o_rd_data     <= 8'h00;
    end else begin
      o_obj_ack     <= obj_ok;
      o_obj_refused <= i_obj_wr && !obj_ok;
      o_alt_ack     <= alt_ok;
      o_alt_refused <= i_alt_wr && !alt_ok;
      if (rd_dec[3]) begin
        o_rd_data <= gen_q[rd_dec[2:0]];
      end else if (map_hit(i_rd_ofs)) begin
        o_rd_data <= map_q[4'(i_rd_ofs - OFS_MAP_BASE)];
      end else begin
        o_rd_data <= 8'h00;
      end
    end
  end

  assign o_force_grant      = i_force_req && (gen_q[IDX_FORCE_LOCK] != VAL_ENABLE);
  assign o_web_enable       = (gen_q[IDX_WEB_LOCK] != VAL_ENABLE);
  assign o_out_src_device   = (gen_q[IDX_OUT_SRC] == VAL_ENABLE);
  assign o_supply_diag_en   = (gen_q[IDX_SUPPLY_REP] == VAL_ENABLE);
  assign o_do_fault_diag_en = (gen_q[IDX_DO_REP] == VAL_ENABLE);

  // outputs follow the word only from a running owner; idle drives them low
  assign run_ok = i_owner_active && i_run;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      pos[c] = word_pos(gen_q[IDX_MAP_MODE], 4'(c), map_q[c]);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_chan_out <= 16'h0000;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        o_chan_out[c] <= run_ok && !pos[c][4] && i_out_word[pos[c][3:0]];
      end
    end
  end

  // inactive table entries simply drop out of the status word
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status_word <= 16'h0000;
    end else begin
      for (int b = 0; b < NUM_CH; b++) begin
        o_status_word[b] <= 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
          if (pos[c] == 5'(b) && (i_owner_active || i_listen_active)) begin
            o_status_word[b] <= i_chan_in[c];
          end
        end
      end
    end
  end

  logic [7:0] in_even;
  logic [7:0] in_odd;
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      in_even[n] = i_chan_in[2*n];
      in_odd[n]  = i_chan_in[2*n+1];
    end
  end
  logic cyc_act;
  assign cyc_act = i_owner_active || i_listen_active;

  property p_obj_lock;
    @(posedge i_clk) disable iff (i_rst)
    i_obj_wr && gen_q[IDX_OBJ_LOCK] == VAL_ENABLE |=> o_obj_refused && !o_obj_ack;
  endproperty
  a_obj_lock: assert property (p_obj_lock) else $error("object write passed lock");

  property p_obj_owner;
    @(posedge i_clk) disable iff (i_rst)
    i_obj_wr && i_owner_active |=> o_obj_refused;
  endproperty
  a_obj_owner: assert property (p_obj_owner) else $error("object write with owner");

  property p_lock_clear;
    @(posedge i_clk) disable iff (i_rst)
    $past(gen_q[IDX_OBJ_LOCK]) == VAL_ENABLE && gen_q[IDX_OBJ_LOCK] != VAL_ENABLE
      |-> $past(commit);
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("object lock cleared");

  property p_alt_conn;
    @(posedge i_clk) disable iff (i_rst)
    i_alt_wr && cyc_act |=> o_alt_refused ##0 $stable(gen_q[alt_dec[2:0]]) or $past(commit);
  endproperty
  a_alt_conn: assert property (p_alt_conn) else $error("alt write during connection");

  property p_commit;
    @(posedge i_clk) disable iff (i_rst)
    commit |=> gen_q[IDX_MAP_MODE] == $past(sh_q[IDX_MAP_MODE]) && map_q[0] == $past(sh_map_q[0]);
  endproperty
  a_commit: assert property (p_commit) else $error("commit did not apply");

  property p_reject;
    @(posedge i_clk) disable iff (i_rst)
    o_cfg_done && o_cfg_err != ERR_NONE |-> $stable(map_q[0]) && $past(chk_err) != ERR_NONE;
  endproperty
  a_reject: assert property (p_reject) else $error("rejected image applied");

  property p_mode_max;
    @(posedge i_clk) disable iff (i_rst)
    gen_q[IDX_MAP_MODE] <= MODE_FREE;
  endproperty
  a_mode_max: assert property (p_mode_max) else $error("mapping mode out of range");

  property p_idle;
    @(posedge i_clk) disable iff (i_rst)
    !run_ok |=> o_chan_out == 16'h0000;
  endproperty
  a_idle: assert property (p_idle) else $error("outputs driven while idle");

  property p_mode01;
    @(posedge i_clk) disable iff (i_rst)
    run_ok && gen_q[IDX_MAP_MODE] <= MODE_SWAP |=> o_chan_out ==
      ($past(gen_q[IDX_MAP_MODE]) == MODE_DEFAULT ? $past(i_out_word)
        : {$past(i_out_word[7:0]), $past(i_out_word[15:8])});
  endproperty
  a_mode01: assert property (p_mode01) else $error("fixed mapping 0/1 wrong");

  property p_mode2;
    @(posedge i_clk) disable iff (i_rst)
    cyc_act && gen_q[IDX_MAP_MODE] == MODE_A_LOW |=> o_status_word == {$past(in_odd), $past(in_even)};
  endproperty
  a_mode2: assert property (p_mode2) else $error("mapping mode 2 wrong");

  property p_mode3;
    @(posedge i_clk) disable iff (i_rst)
    cyc_act && gen_q[IDX_MAP_MODE] == MODE_B_LOW |=> o_status_word == {$past(in_even), $past(in_odd)};
  endproperty
  a_mode3: assert property (p_mode3) else $error("mapping mode 3 wrong");

  property p_free;
    @(posedge i_clk) disable iff (i_rst)
    run_ok && gen_q[IDX_MAP_MODE] == MODE_FREE && map_q[0] < MAP_INACTIVE
      |=> o_chan_out[0] == $past(i_out_word[map_q[0][3:0]]);
  endproperty
  a_free: assert property (p_free) else $error("free mapping wrong");

  c_commit: cover property (@(posedge i_clk) disable iff (i_rst) commit);
  c_dup:    cover property (@(posedge i_clk) disable iff (i_rst) o_cfg_err == ERR_MAP_DUP);
  c_objwr:  cover property (@(posedge i_clk) disable iff (i_rst) obj_ok);
  c_full:   cover property (@(posedge i_clk) disable iff (i_rst) !f_ready);
endmodule
`default_nettype wire

// ### tb/iocm_scanner.sv
`timescale 1ns/1ps
`default_nettype none
module iocm_scanner import iocm_pkg::*; (
  // clock and answers from the block
  input  wire logic             i_clk,
  input  wire logic             i_cfg_ready,
  input  wire logic             i_cfg_done,
  input  wire logic [3:0]       i_cfg_err,
  // connection state and output data
  output logic                  o_owner_active,
  output logic                  o_owner_setup,
  output logic                  o_listen_active,
  output logic                  o_run,
  output logic [15:0]           o_out_word,
  // configuration image stream
  output logic                  o_cfg_valid,
  output logic [OFS_W-1:0]      o_cfg_ofs,
  output logic [7:0]            o_cfg_data,
  output logic                  o_cfg_last
);
  initial begin
    o_owner_active  = 1'b0;
    o_owner_setup   = 1'b0;
    o_listen_active = 1'b0;
    o_run           = 1'b0;
    o_out_word      = 16'h0000;
    o_cfg_valid     = 1'b0;
    o_cfg_ofs       = 9'h000;
    o_cfg_data      = 8'h00;
    o_cfg_last      = 1'b0;
  end

  // idle header keeps outputs off until the run bit is sent
  task automatic set_run(input logic run, input logic [15:0] word);
    o_run      = run & o_owner_active;
    o_out_word = word;
  endtask

  task automatic close_all();
    o_owner_active  = 1'b0;
    o_listen_active = 1'b0;
    o_run           = 1'b0;
  endtask

  // heartbeat only: no output data and no image
  task automatic open_listen();
    close_all();
    o_listen_active = 1'b1;
  endtask

  // owner setup: stream the image, connection stands only if accepted
  task automatic open_owner(input logic [16:0] img[$], output logic [3:0] err,
                            output logic done);
    close_all();
    o_owner_setup = 1'b1;
    foreach (img[k]) begin
      o_cfg_valid = 1'b1;
      o_cfg_ofs   = img[k][16:8];
      o_cfg_data  = img[k][7:0];
      o_cfg_last  = (k == img.size() - 1);
      do @(posedge i_clk); while (i_cfg_ready !== 1'b1);
      #1;
    end
    o_cfg_valid = 1'b0;
    o_cfg_last  = 1'b0;
    // released bus must not keep showing the last byte
    o_cfg_data  = ~o_cfg_data;
    done        = 1'b0;
    for (int n = 0; n < 40 && done !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
      done = i_cfg_done;
    end
    err            = i_cfg_err;
    o_owner_setup  = 1'b0;
    o_owner_active = (err === ERR_NONE) && (done === 1'b1);
  endtask
endmodule
`default_nettype wire

// ### tb/iocm_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("ERROR %s expected %h seen %h", name, exp, got); \
    end \
  end
module iocm_top_tb_top import iocm_pkg::*;;
  typedef struct {
    logic [7:0]  mode;
    logic [7:0]  gen;
    logic [15:0] word;
    logic [15:0] chan;
  } iocm_row_s;
  // word 8102 has bits 1, 8 and 15 set; mode 4 swaps entries of channels 0 and 1
  iocm_row_s rows [5] = '{'{8'h00, 8'h01, 16'h8102, 16'h8102},
                          '{8'h01, 8'h00, 16'h8102, 16'h0281},
                          '{8'h02, 8'h01, 16'h8102, 16'h8006},
                          '{8'h03, 8'h00, 16'h8102, 16'h4009},
                          '{8'h04, 8'h01, 16'h8102, 16'h8101}};
  logic clk = 1'b0, rst = 1'b1, force_req = 1'b1, obj_wr = 1'b0, alt_wr = 1'b0;
  logic [OFS_W-1:0] obj_ofs = 9'h000, alt_ofs = 9'h000, rd_ofs = 9'h000, cfg_ofs;
  logic [7:0] obj_data = 8'h00, alt_data = 8'h00, cfg_data, rdv, rd_data;
  logic [15:0] chan_in = 16'h0000, out_word, chan_out, status_word;
  logic owner, setup, listen, run, cfg_valid, cfg_last, cfg_ready, cfg_done, done;
  logic obj_ack, obj_ref, alt_ack, alt_ref, grant, web_en, src_dev, sup_en, do_en;
  logic [3:0] cfg_err, err;
  logic [16:0] img[$];
  int fail_count = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;

  iocm_top i_iocm_top (.i_clk(clk), .i_rst(rst), .i_owner_active(owner),
    .i_owner_setup(setup), .i_listen_active(listen), .i_run(run),
    .i_cfg_valid(cfg_valid), .o_cfg_ready(cfg_ready), .i_cfg_ofs(cfg_ofs),
    .i_cfg_data(cfg_data), .i_cfg_last(cfg_last), .o_cfg_done(cfg_done), .o_cfg_err(cfg_err),
    .i_obj_wr(obj_wr), .i_obj_ofs(obj_ofs), .i_obj_data(obj_data), .o_obj_ack(obj_ack),
    .o_obj_refused(obj_ref), .i_alt_wr(alt_wr), .i_alt_ofs(alt_ofs), .i_alt_data(alt_data),
    .o_alt_ack(alt_ack), .o_alt_refused(alt_ref), .i_rd_ofs(rd_ofs), .o_rd_data(rd_data),
    .i_force_req(force_req), .o_force_grant(grant), .o_web_enable(web_en),
    .o_out_src_device(src_dev), .o_supply_diag_en(sup_en), .o_do_fault_diag_en(do_en),
    .i_out_word(out_word), .o_chan_out(chan_out), .i_chan_in(chan_in),
    .o_status_word(status_word));

  iocm_scanner i_iocm_scanner (.i_clk(clk), .i_cfg_ready(cfg_ready), .i_cfg_done(cfg_done),
    .i_cfg_err(cfg_err), .o_owner_active(owner), .o_owner_setup(setup),
    .o_listen_active(listen), .o_run(run), .o_out_word(out_word), .o_cfg_valid(cfg_valid),
    .o_cfg_ofs(cfg_ofs), .o_cfg_data(cfg_data), .o_cfg_last(cfg_last));

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic rd(input logic [OFS_W-1:0] ofs, output logic [7:0] val);
    rd_ofs = ofs;
    @(posedge clk);
    #1;
    val = rd_data;
  endtask

  // one strobe per call; the edge between calls keeps back-to-back writes apart
  task automatic wr(input logic alt, input logic [OFS_W-1:0] ofs, input logic [7:0] dat,
                    input logic ack);
    obj_ofs  = ofs;
    alt_ofs  = ofs;
    obj_data = dat;
    alt_data = dat;
    obj_wr   = ~alt;
    alt_wr   = alt;
    @(posedge clk);
    #1;
    `CHK("write ack", ack, alt ? alt_ack : obj_ack)
    `CHK("write refused", ~ack, alt ? alt_ref : obj_ref)
    obj_wr = 1'b0;
    alt_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic owner_img(input logic [3:0] exp_err);
    i_iocm_scanner.open_owner(img, err, done);
    `CHK("cfg done", 1'b1, done)
    `CHK("cfg err", exp_err, err)
  endtask

  initial begin
    #(5 * 20000);
    fail_count++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int r = 0; r < 5; r++) begin
      img = '{{9'h001, rows[r].gen}, {9'h002, rows[r].gen}, {9'h003, rows[r].gen},
              {9'h004, rows[r].gen}, {9'h005, rows[r].gen}, {9'h01F, rows[r].mode},
              {9'h020, 8'h01}, {9'h021, 8'h00}};
      owner_img(ERR_NONE);
      i_iocm_scanner.set_run(1'b1, rows[r].word);
      chan_in = rows[r].chan;
      repeat (2) @(posedge clk);
      #1;
      `CHK("chan out", rows[r].chan, chan_out)
      `CHK("status word", rows[r].word, status_word)
      `CHK("force grant", rows[r].gen != 8'h01, grant)
      `CHK("web enable", rows[r].gen != 8'h01, web_en)
      `CHK("out source", rows[r].gen == 8'h01, src_dev)
      `CHK("supply diag", rows[r].gen == 8'h01, sup_en)
      `CHK("output diag", rows[r].gen == 8'h01, do_en)
      rd(OFS_MAP_MODE, rdv);
      `CHK("mode readback", rows[r].mode, rdv)
      $display("row %0d done", r);
    end
    i_iocm_scanner.close_all();
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    `CHK("web enable reset", 1'b1, web_en)
    `CHK("cfg ready reset", 1'b1, cfg_ready)
    force_req = 1'b0;
    rd(OFS_FORCE_LOCK, rdv);
    `CHK("force lock reset", 8'h00, rdv)
    `CHK("force without request", 1'b0, grant)
    rd(OFS_WEB_LOCK, rdv);
    `CHK("web lock reset", 8'h00, rdv)
    rd(OFS_OBJ_LOCK, rdv);
    `CHK("object lock reset", 8'h00, rdv)
    rd(9'h010, rdv);
    `CHK("unmapped read", 8'h00, rdv)
    $display("reset test done");
    wr(1'b0, OFS_WEB_LOCK, 8'h01, 1'b1);
    `CHK("web enable locked", 1'b0, web_en)
    wr(1'b0, OFS_OBJ_LOCK, 8'h01, 1'b1);
    wr(1'b0, OFS_WEB_LOCK, 8'h00, 1'b0);
    wr(1'b0, OFS_OBJ_LOCK, 8'h00, 1'b0);
    img = '{{9'h018, 8'h00}};
    owner_img(ERR_NONE);
    rd(OFS_OBJ_LOCK, rdv);
    `CHK("object lock cleared", 8'h00, rdv)
    wr(1'b0, OFS_WEB_LOCK, 8'h00, 1'b0);
    $display("object lock test done");
    wr(1'b1, OFS_OUT_SRC, 8'h01, 1'b0);
    i_iocm_scanner.open_listen();
    wr(1'b1, OFS_OUT_SRC, 8'h01, 1'b0);
    i_iocm_scanner.close_all();
    wr(1'b1, OFS_OUT_SRC, 8'h01, 1'b1);
    `CHK("alt out source", 1'b1, src_dev)
    img = '{{9'h01F, 8'h00}};
    owner_img(ERR_NONE);
    rd(OFS_OUT_SRC, rdv);
    `CHK("alt setting overwritten", 8'h00, rdv)
    i_iocm_scanner.close_all();
    wr(1'b0, OFS_ALT_LOCK, 8'h01, 1'b1);
    wr(1'b1, OFS_SUPPLY_REP, 8'h00, 1'b0);
    $display("alternative interface test done");
    img = '{{9'h01F, 8'h05}};
    owner_img(ERR_MODE);
    img = '{{9'h020, 8'h11}};
    owner_img(ERR_MAP_RANGE);
    img = '{{9'h01F, 8'h04}, {9'h020, 8'h01}};
    owner_img(ERR_MAP_DUP);
    rd(OFS_ALT_LOCK, rdv);
    `CHK("rejected image not applied", 8'h01, rdv)
    $display("reject test done");
    img = '{{9'h01F, 8'h00}};
    owner_img(ERR_NONE);
    i_iocm_scanner.set_run(1'b0, 16'hFFFF);
    chan_in = 16'h0003;
    repeat (2) @(posedge clk);
    #1;
    `CHK("idle outputs off", 16'h0000, chan_out)
    i_iocm_scanner.open_listen();
    repeat (2) @(posedge clk);
    #1;
    `CHK("listen status", 16'h0003, status_word)
    `CHK("listen outputs off", 16'h0000, chan_out)
    $display("connection gating test done");
    wrap_up();
  end
endmodule
`default_nettype wire
